// ---- code_select.sv ----
// Sleep/normal voltage code selector with a registered output.
// Assumes the sleep indication comes from logic on the same clock.
`timescale 1ns/10ps
module code_select #(
    parameter int WIDTH = 4                         // Code width
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Selection
    input  wire logic             sleep_active,
    input  wire logic [WIDTH-1:0] normal_code,
    input  wire logic [WIDTH-1:0] sleep_code,
    // Code to the regulator
    output logic      [WIDTH-1:0] code_q
);

    logic [WIDTH-1:0] code_d;                       // Next regulator code

    // ---------------------------------------------------------------
    // Selection
    // ---------------------------------------------------------------
    // Pick the sleep code in sleep, else the normal code
    always_comb
    begin
        if (sleep_active)
        begin
            code_d = sleep_code;
        end
        else
        begin
            code_d = normal_code;
        end
    end

    // Register the chosen code; stored fields stay untouched
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            code_q <= '0;
        end
        else
        begin
            code_q <= code_d;
        end
    end

endmodule : code_select

// ---- reg_host_model.sv ----
// Host model driving the bank's same-clock strobe port at falling edges.
// Assumes a read answers with valid one cycle after the strobe edge.
`timescale 1ns/10ps
module reg_host_model
    import regulator_voltage_control_pkg::*;
(
    // Clock
    input  wire logic                                     core_clk,
    // Register port toward the bank
    output regulator_voltage_control_pkg::reg_addr_t      reg_addr,
    output logic                                          reg_wr_en,
    output regulator_voltage_control_pkg::reg_data_t      reg_wr_data,
    output logic                                          reg_rd_en,
    input  wire regulator_voltage_control_pkg::reg_data_t reg_rd_data_q,
    input  wire logic                                     reg_rd_valid_q
);
    // Idle port at time zero
    initial
    begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end

    // One transfer: write, read, or both in the same cycle
    task automatic xfer(input logic wr, input logic rd, input reg_addr_t a,
                        input reg_data_t d, output reg_data_t q, output logic ok);
        int n;
        q  = 8'h00;
        ok = !rd;
        @(negedge core_clk);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr_en   = wr;
        reg_rd_en   = rd;
        @(negedge core_clk);
        // Released lines show garbage, not the last value
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b0;
        reg_addr    = ~a;
        reg_wr_data = ~d;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (reg_rd_valid_q === 1'b1)
            begin
                q  = reg_rd_data_q;
                ok = 1'b1;
            end
            else
                @(negedge core_clk);
        end
    endtask : xfer
endmodule : reg_host_model

// ---- regs_chk.sv ----
// Assertion checker for the regulator register bank, on its top ports.
// Assumes one clock core_clk and asynchronous active-low nrst.
`timescale 1ns/10ps
module regs_chk
    import regulator_voltage_control_pkg::*;
(
    // Clock and reset
    input wire logic                                      core_clk,
    input wire logic                                      nrst,
    // Register port
    input wire regulator_voltage_control_pkg::reg_addr_t  reg_addr,
    input wire logic                                      reg_wr_en,
    input wire regulator_voltage_control_pkg::reg_data_t  reg_wr_data,
    input wire logic                                      reg_rd_en,
    input wire regulator_voltage_control_pkg::reg_data_t  reg_rd_data_q,
    input wire logic                                      reg_rd_valid_q,
    // Device state
    input wire logic                                      sleep_active,
    input wire regulator_voltage_control_pkg::ctrl_vec_t  control_pin_enable,
    input wire regulator_voltage_control_pkg::conv_code_t converter_six_normal_code,
    // Analog side
    input wire regulator_voltage_control_pkg::conv_code_t converter_six_code_q,
    input wire regulator_voltage_control_pkg::lin_code_t  linear_reg_two_code_q,
    input wire regulator_voltage_control_pkg::lin_code_t  linear_reg_three_code_q,
    input wire logic                                      controller_one_pwm_select_q,
    input wire logic                                      controller_two_pwm_select_q,
    input wire logic                                      controller_three_pwm_select_q,
    input wire regulator_voltage_control_pkg::ctrl_vec_t  controller_run_q
);
    // ---------------------------------------------------------------
    // Shadow registers and expected outputs
    // ---------------------------------------------------------------
    logic [7:0] sh_q [4];    // Shadow by address low bits, index 0 is 9C
    logic       hit;         // Address in mapped range
    logic [7:0] wmask;       // Writable bits of addressed register
    reg_data_t  rd_exp_q;    // Expected read answer, old value on collision
    reg_addr_t  rd_addr_q;   // Address of the previous cycle
    ctrl_vec_t  run_exp_q;   // Expected run permissions
    ctrl_vec_t  pwm_exp_q;   // Expected mode selects, bit 0 controller one
    lin_code_t  two_exp_q;   // Expected linear two code
    lin_code_t  three_exp_q; // Expected linear three code
    conv_code_t six_exp_q;   // Expected converter six code

    // Decode of the addressed register
    always_comb
    begin
        hit   = (reg_addr >= 8'h99) && (reg_addr <= 8'h9C);
        wmask = (reg_addr == 8'h99) ? 8'hFE : ((reg_addr == 8'h9C) ? 8'h3F : 8'hFF);
    end

    // Mirror of the bank, one cycle ahead of the outputs
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_q        <= '{8'h27, 8'h00, 8'h00, 8'h00};
            rd_exp_q    <= 8'h00;
            rd_addr_q   <= 8'h00;
            run_exp_q   <= 3'h0;
            pwm_exp_q   <= 3'h0;
            two_exp_q   <= 4'h0;
            three_exp_q <= 4'h0;
            six_exp_q   <= 7'h00;
        end
        else
        begin
            if (reg_wr_en && hit)
                sh_q[reg_addr[1:0]] <= reg_wr_data & wmask;
            rd_exp_q    <= hit ? sh_q[reg_addr[1:0]] : 8'h00;
            rd_addr_q   <= reg_addr;
            run_exp_q   <= control_pin_enable & sh_q[0][2:0];
            pwm_exp_q   <= sh_q[0][5:3];
            two_exp_q   <= sleep_active ? sh_q[2][7:4] : sh_q[2][3:0];
            three_exp_q <= sleep_active ? sh_q[3][7:4] : sh_q[3][3:0];
            six_exp_q   <= sleep_active ? sh_q[1][7:1] : converter_six_normal_code;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence read_req;
        reg_rd_en;
    endsequence
    sequence read_ans;
        reg_rd_valid_q && (reg_rd_data_q == rd_exp_q);
    endsequence

    a_read_answer: assert property (read_req |=> read_ans)
        else $error("read answer missing or wrong");
    a_valid_cause: assert property (reg_rd_valid_q |-> $past(reg_rd_en))
        else $error("read valid without a read strobe");
    a_data_holds: assert property (!reg_rd_valid_q |-> $stable(reg_rd_data_q))
        else $error("read data moved without a read");
    a_reserved_zero: assert property (reg_rd_valid_q && rd_addr_q == 8'h9C |-> reg_rd_data_q[7:6] == 2'b00)
        else $error("reserved control bits read nonzero");
    a_run_gate: assert property (controller_run_q == run_exp_q)
        else $error("run permission wrong");
    a_mode_select: assert property ({controller_three_pwm_select_q, controller_two_pwm_select_q, controller_one_pwm_select_q} == pwm_exp_q)
        else $error("mode select wrong");
    a_lin_two_code: assert property (linear_reg_two_code_q == two_exp_q)
        else $error("linear two code wrong");
    a_lin_three_code: assert property (linear_reg_three_code_q == three_exp_q)
        else $error("linear three code wrong");
    a_conv_six_code: assert property (converter_six_code_q == six_exp_q)
        else $error("converter six code wrong");
endmodule : regs_chk

bind regulator_voltage_control_regs regs_chk u_chk (.core_clk, .nrst, .reg_addr, .reg_wr_en,
    .reg_wr_data, .reg_rd_en, .reg_rd_data_q, .reg_rd_valid_q, .sleep_active,
    .control_pin_enable, .converter_six_normal_code, .converter_six_code_q,
    .linear_reg_two_code_q, .linear_reg_three_code_q, .controller_one_pwm_select_q,
    .controller_two_pwm_select_q, .controller_three_pwm_select_q, .controller_run_q);

// ---- regulator_voltage_control_pkg.sv ----
// Constants shared by the regulator voltage and controller register bank.
// Assumes an 8-bit register address space driven by the serial host logic.
package regulator_voltage_control_pkg;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int ADDR_W        = 8;    // Register address width
    localparam int DATA_W        = 8;    // Register data width
    localparam int CONV_CODE_W   = 7;    // Converter six voltage code width
    localparam int LIN_CODE_W    = 4;    // Linear regulator voltage code width
    localparam int NUM_CTRL      = 3;    // Number of step-down controllers

    typedef logic [ADDR_W-1:0]      reg_addr_t;
    typedef logic [DATA_W-1:0]      reg_data_t;
    typedef logic [CONV_CODE_W-1:0] conv_code_t;
    typedef logic [LIN_CODE_W-1:0]  lin_code_t;
    typedef logic [NUM_CTRL-1:0]    ctrl_vec_t;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam reg_addr_t OFS_CONV_SIX_SLEEP  = 8'h99; // Converter six sleep code
    localparam reg_addr_t OFS_LIN_TWO_VOLT    = 8'h9A; // Linear two codes
    localparam reg_addr_t OFS_LIN_THREE_VOLT  = 8'h9B; // Linear three codes
    localparam reg_addr_t OFS_CTRL_MODE_DIS   = 8'h9C; // Controller mode/force-off

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CONV_SLEEP_LSB  = 1;  // Converter six code bits 7:1
    localparam int CONV_SLEEP_MSB  = 7;
    localparam int LIN_SLEEP_LSB   = 4;  // Linear sleep code bits 7:4
    localparam int LIN_SLEEP_MSB   = 7;
    localparam int LIN_NORM_LSB    = 0;  // Linear normal code bits 3:0
    localparam int LIN_NORM_MSB    = 3;
    localparam int MODE_LSB        = 3;  // Mode bits 5:3, controller one at 3
    localparam int MODE_MSB        = 5;
    localparam int RUN_LSB         = 0;  // Force-off bits 2:0, controller one at 0
    localparam int RUN_MSB         = 2;

    // Writable bit masks; other bits are reserved and read as zero
    localparam reg_data_t CONV_SLEEP_MASK = 8'hFE;
    localparam reg_data_t CTRL_MASK       = 8'h3F;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam reg_data_t RST_CONV_SIX_SLEEP = 8'h00;
    localparam reg_data_t RST_LIN_TWO_VOLT   = 8'h00;
    localparam reg_data_t RST_LIN_THREE_VOLT = 8'h00;
    localparam reg_data_t RST_CTRL_MODE_DIS  = 8'h27; // Controller three PWM, all run
    localparam reg_data_t READ_ZERO          = 8'h00; // Unmapped read answer

endpackage : regulator_voltage_control_pkg

// ---- regulator_voltage_control_regs.sv ----
// Register bank for converter six sleep code, linear two/three codes and
// step-down controller mode and force-off bits.
// Assumes a same-clock register port from the serial host logic and
// same-clock pin-enable and sleep indications from the sequencing logic.
`timescale 1ns/10ps
module regulator_voltage_control_regs
    import regulator_voltage_control_pkg::*;
(
    // Clock and reset
    input  wire logic                                     core_clk,
    input  wire logic                                     nrst,
    // Register port from host interface logic
    input  wire regulator_voltage_control_pkg::reg_addr_t reg_addr,
    input  wire logic                                     reg_wr_en,
    input  wire regulator_voltage_control_pkg::reg_data_t reg_wr_data,
    input  wire logic                                     reg_rd_en,
    output regulator_voltage_control_pkg::reg_data_t      reg_rd_data_q,
    output logic                                          reg_rd_valid_q,
    // Device state from sequencing logic
    input  wire logic                                     sleep_active,
    input  wire regulator_voltage_control_pkg::ctrl_vec_t control_pin_enable,
    input  wire regulator_voltage_control_pkg::conv_code_t converter_six_normal_code,
    // Converter six code to the analog side
    output regulator_voltage_control_pkg::conv_code_t     converter_six_code_q,
    // Linear regulator codes to the analog side
    output regulator_voltage_control_pkg::lin_code_t      linear_reg_two_code_q,
    output regulator_voltage_control_pkg::lin_code_t      linear_reg_three_code_q,
    // Step-down controller controls
    output logic                                          controller_one_pwm_select_q,
    output logic                                          controller_two_pwm_select_q,
    output logic                                          controller_three_pwm_select_q,
    output regulator_voltage_control_pkg::ctrl_vec_t      controller_run_q
);

    import regulator_voltage_control_pkg::*;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    reg_data_t conv_six_sleep_q;                    // Converter six sleep register
    reg_data_t conv_six_sleep_d;
    reg_data_t lin_two_volt_q;                      // Linear two voltage register
    reg_data_t lin_two_volt_d;
    reg_data_t lin_three_volt_q;                    // Linear three voltage register
    reg_data_t lin_three_volt_d;
    reg_data_t ctrl_mode_dis_q;                     // Controller control register
    reg_data_t ctrl_mode_dis_d;

    // Read path
    reg_data_t rd_data_d;                           // Next read answer
    logic      rd_valid_d;                          // Next read valid

    // Controller outputs
    ctrl_vec_t mode_sel_d;                          // Next PWM selects
    ctrl_vec_t mode_sel_q;                          // Registered PWM selects
    ctrl_vec_t run_d;                               // Next run permissions

    // Field views
    ctrl_vec_t force_off_n;                         // Register force-off bits
    ctrl_vec_t mode_bits;                           // Register mode bits

    assign force_off_n = ctrl_mode_dis_q[RUN_MSB:RUN_LSB];
    assign mode_bits   = ctrl_mode_dis_q[MODE_MSB:MODE_LSB];

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // Decode a write and store writable bits only
    always_comb
    begin
        conv_six_sleep_d = conv_six_sleep_q;
        lin_two_volt_d   = lin_two_volt_q;
        lin_three_volt_d = lin_three_volt_q;
        ctrl_mode_dis_d  = ctrl_mode_dis_q;
        if (reg_wr_en)
        begin
            case (reg_addr)
                OFS_CONV_SIX_SLEEP:
                begin
                    // Code bits kept, bit 0 held at zero
                    conv_six_sleep_d = reg_wr_data & CONV_SLEEP_MASK;
                end
                OFS_LIN_TWO_VOLT:
                begin
                    // Both nibbles writable
                    lin_two_volt_d = reg_wr_data;
                end
                OFS_LIN_THREE_VOLT:
                begin
                    // Both nibbles writable
                    lin_three_volt_d = reg_wr_data;
                end
                OFS_CTRL_MODE_DIS:
                begin
                    // Mode and force-off bits kept, bits 7:6 held at zero
                    ctrl_mode_dis_d = reg_wr_data & CTRL_MASK;
                end
                default:
                begin
                    // Unmapped write ignored
                    conv_six_sleep_d = conv_six_sleep_q;
                end
            endcase
        end
    end

    // Register storage flops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            conv_six_sleep_q <= RST_CONV_SIX_SLEEP;
            lin_two_volt_q   <= RST_LIN_TWO_VOLT;
            lin_three_volt_q <= RST_LIN_THREE_VOLT;
            ctrl_mode_dis_q  <= RST_CTRL_MODE_DIS;
        end
        else
        begin
            conv_six_sleep_q <= conv_six_sleep_d;
            lin_two_volt_q   <= lin_two_volt_d;
            lin_three_volt_q <= lin_three_volt_d;
            ctrl_mode_dis_q  <= ctrl_mode_dis_d;
        end
    end

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------
    // Return stored value one cycle after the read strobe
    always_comb
    begin
        rd_valid_d = reg_rd_en;
        rd_data_d  = reg_rd_data_q;
        if (reg_rd_en)
        begin
            case (reg_addr)
                OFS_CONV_SIX_SLEEP:
                begin
                    // Reserved bit 0 reads zero
                    rd_data_d = conv_six_sleep_q & CONV_SLEEP_MASK;
                end
                OFS_LIN_TWO_VOLT:
                begin
                    // Sleep and normal nibbles
                    rd_data_d = lin_two_volt_q;
                end
                OFS_LIN_THREE_VOLT:
                begin
                    // Sleep and normal nibbles
                    rd_data_d = lin_three_volt_q;
                end
                OFS_CTRL_MODE_DIS:
                begin
                    // Reserved bits 7:6 read zero
                    rd_data_d = ctrl_mode_dis_q & CTRL_MASK;
                end
                default:
                begin
                    // Unmapped address reads zero
                    rd_data_d = READ_ZERO;
                end
            endcase
        end
    end

    // Read answer flops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rd_data_q  <= READ_ZERO;
            reg_rd_valid_q <= 1'b0;
        end
        else
        begin
            reg_rd_data_q  <= rd_data_d;
            reg_rd_valid_q <= rd_valid_d;
        end
    end

    // ---------------------------------------------------------------
    // Controller mode and force-off
    // ---------------------------------------------------------------
    // Per controller: mode passes, run needs pin enable and register bit
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTRL; gi++)
        begin : g_ctrl
            // Bit one selects forced PWM, zero automatic
            assign mode_sel_d[gi] = mode_bits[gi];
            // Zero in the register overrides the pin enable
            assign run_d[gi]      = control_pin_enable[gi] & force_off_n[gi];
        end
    endgenerate

    // Controller output flops
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_sel_q       <= '0;
            controller_run_q <= '0;
        end
        else
        begin
            mode_sel_q       <= mode_sel_d;
            controller_run_q <= run_d;
        end
    end

    // Mode selects straight from their flops
    always_comb
    begin
        controller_one_pwm_select_q   = mode_sel_q[0];
        controller_two_pwm_select_q   = mode_sel_q[1];
        controller_three_pwm_select_q = mode_sel_q[2];
    end

    // ---------------------------------------------------------------
    // Sleep/normal code selection
    // ---------------------------------------------------------------
    // Converter six: sleep code here, normal code from neighbour
    code_select #(
        .WIDTH (CONV_CODE_W)
    ) u_conv_six_sel (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .sleep_active (sleep_active),
        .normal_code  (converter_six_normal_code),
        .sleep_code   (conv_six_sleep_q[CONV_SLEEP_MSB:CONV_SLEEP_LSB]),
        .code_q       (converter_six_code_q)
    );

    // Linear regulator two
    code_select #(
        .WIDTH (LIN_CODE_W)
    ) u_lin_two_sel (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .sleep_active (sleep_active),
        .normal_code  (lin_two_volt_q[LIN_NORM_MSB:LIN_NORM_LSB]),
        .sleep_code   (lin_two_volt_q[LIN_SLEEP_MSB:LIN_SLEEP_LSB]),
        .code_q       (linear_reg_two_code_q)
    );

    // Linear regulator three
    code_select #(
        .WIDTH (LIN_CODE_W)
    ) u_lin_three_sel (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .sleep_active (sleep_active),
        .normal_code  (lin_three_volt_q[LIN_NORM_MSB:LIN_NORM_LSB]),
        .sleep_code   (lin_three_volt_q[LIN_SLEEP_MSB:LIN_SLEEP_LSB]),
        .code_q       (linear_reg_three_code_q)
    );

endmodule : regulator_voltage_control_regs

// ---- regulator_voltage_control_regs_tb.sv ----
// Self-checking bench for the regulator register bank.
// Assumes the host model and bound checker compile alongside.
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module regulator_voltage_control_regs_tb;
    import regulator_voltage_control_pkg::*;
    logic       core_clk, nrst, sleep_active, reg_wr_en, reg_rd_en, reg_rd_valid_q;
    logic       controller_one_pwm_select_q, controller_two_pwm_select_q;
    logic       controller_three_pwm_select_q, ok;
    ctrl_vec_t  control_pin_enable, controller_run_q;
    conv_code_t converter_six_normal_code, converter_six_code_q;
    lin_code_t  linear_reg_two_code_q, linear_reg_three_code_q;
    reg_addr_t  reg_addr;
    reg_data_t  reg_wr_data, reg_rd_data_q, rq;
    int         failures, compares, cycles;

    regulator_voltage_control_regs u_dut (.core_clk, .nrst, .reg_addr, .reg_wr_en,
        .reg_wr_data, .reg_rd_en, .reg_rd_data_q, .reg_rd_valid_q, .sleep_active,
        .control_pin_enable, .converter_six_normal_code, .converter_six_code_q,
        .linear_reg_two_code_q, .linear_reg_three_code_q, .controller_one_pwm_select_q,
        .controller_two_pwm_select_q, .controller_three_pwm_select_q, .controller_run_q);
    reg_host_model u_host (.core_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
        .reg_rd_data_q, .reg_rd_valid_q);

    // Clock and hang limit
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        u_host.xfer(1'b1, 1'b0, a, d, rq, ok);
    endtask : wr
    task automatic rd_chk(input reg_addr_t a, input reg_data_t e);
        u_host.xfer(1'b0, 1'b1, a, 8'h00, rq, ok);
        `CHK(ok, 1'b1)
        `CHK(rq, e)
    endtask : rd_chk
    task automatic settle;
        repeat (2) @(negedge core_clk);
    endtask : settle
    task automatic do_reset(input int n);
        nrst = 1'b0;
        repeat (n) @(negedge core_clk);
        nrst = 1'b1;
    endtask : do_reset

    // Reset values, unmapped read, outputs after reset
    task automatic test_reset;
        rd_chk(8'h99, 8'h00);
        rd_chk(8'h9A, 8'h00);
        rd_chk(8'h9B, 8'h00);
        rd_chk(8'h9C, 8'h27);
        rd_chk(8'h9D, 8'h00);
        `CHK(controller_three_pwm_select_q, 1'b1)
        `CHK(controller_run_q, 3'h7)
        $display("test_reset done");
    endtask : test_reset

    // Field access, reserved bits, sleep and normal selection
    task automatic test_fields;
        wr(8'h99, 8'hFF);
        rd_chk(8'h99, 8'hFE);
        wr(8'h9A, 8'hA5);
        rd_chk(8'h9A, 8'hA5);
        wr(8'h9B, 8'h3C);
        rd_chk(8'h9B, 8'h3C);
        settle();
        `CHK(linear_reg_two_code_q, 4'h5)
        `CHK(linear_reg_three_code_q, 4'hC)
        `CHK(converter_six_code_q, 7'h2B)
        sleep_active = 1'b1;
        settle();
        `CHK(linear_reg_two_code_q, 4'hA)
        `CHK(linear_reg_three_code_q, 4'h3)
        `CHK(converter_six_code_q, 7'h7F)
        rd_chk(8'h9A, 8'hA5);
        sleep_active = 1'b0;
        $display("test_fields done");
    endtask : test_fields

    // Mode and force-off combinations against pin enables
    task automatic test_ctrl;
        reg_data_t v [4];
        ctrl_vec_t p [4];
        v = '{8'h15, 8'h2A, 8'h00, 8'hFF};
        p = '{3'h7, 3'h5, 3'h2, 3'h7};
        for (int i = 0; i < 4; i++)
        begin
            control_pin_enable = p[i];
            wr(8'h9C, v[i]);
            settle();
            `CHK({controller_three_pwm_select_q, controller_two_pwm_select_q,
                  controller_one_pwm_select_q}, v[i][5:3])
            `CHK(controller_run_q, p[i] & v[i][2:0])
            rd_chk(8'h9C, v[i] & 8'h3F);
        end
        $display("test_ctrl done");
    endtask : test_ctrl

    // Read and write in one cycle, unmapped write
    task automatic test_collide;
        wr(8'h9A, 8'h5A);
        u_host.xfer(1'b1, 1'b1, 8'h9A, 8'hC3, rq, ok);
        `CHK(rq, 8'h5A)
        rd_chk(8'h9A, 8'hC3);
        wr(8'h9D, 8'hFF);
        rd_chk(8'h9D, 8'h00);
        rd_chk(8'h9B, 8'h3C);
        $display("test_collide done");
    endtask : test_collide

    // Reset in mid-run restores defaults
    task automatic test_midreset;
        do_reset(2);
        rd_chk(8'h9C, 8'h27);
        rd_chk(8'h9A, 8'h00);
        `CHK(controller_run_q, 3'h7)
        $display("test_midreset done");
    endtask : test_midreset

    // Main sequence
    initial
    begin
        failures                  = 0;
        compares                  = 0;
        cycles                    = 0;
        sleep_active              = 1'b0;
        control_pin_enable        = 3'h7;
        converter_six_normal_code = 7'h2B;
        do_reset(6);
        test_reset();
        test_fields();
        test_ctrl();
        test_collide();
        test_midreset();
        print_verdict();
    end
endmodule : regulator_voltage_control_regs_tb
